/* rtl/card_lock_pkg.sv */
// Shared constants and types of the card password lock block.
`default_nettype none
package card_lock_pkg;
	// Mode byte field positions.
	localparam int MODE_SET_BIT = 0;
	localparam int MODE_CLR_BIT = 1;
	localparam int MODE_LOCK_BIT = 2;
	localparam int MODE_ERASE_BIT = 3;
	localparam logic [7:0] MODE_ERASE_ONLY = 8'h08;
	localparam logic [3:0] MODE_RSVD_ZERO = 4'h0;
	// Password store geometry and legal lengths.
	localparam int SECRET_BYTES = 16;
	localparam int BUF_BYTES = 2 + 2 * SECRET_BYTES;
	localparam logic [7:0] LEN_MIN = 8'h01;
	localparam logic [7:0] LEN_MAX = 8'h10;
	localparam logic [7:0] LEN_NONE = 8'h00;
	localparam logic [8:0] HDR_BYTES = 9'h002;
	localparam logic [3:0] CRC_LAST = 4'hF;
	// Command classes that a locked card still serves.
	localparam logic [3:0] CLASS_BASIC = 4'h0;
	localparam logic [3:0] CLASS_LOCK = 4'h7;
	// Register byte offsets on the APB.
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_BLKLEN = 12'h004;
	localparam logic [11:0] OFS_STATUS = 12'h008;
	localparam logic [11:0] OFS_SECLEN = 12'h00C;
	localparam int CTRL_ARM_BIT = 0;
	localparam int STAT_LOCKED_BIT = 0;
	localparam int STAT_FAIL_BIT = 1;
	localparam int STAT_BUSY_BIT = 2;
	localparam int STAT_RX_BIT = 3;
	localparam logic [7:0] BLKLEN_RESET = 8'h00;
	// Store update busy time.
	localparam int CLK_PERIOD_NS = 10;
	localparam int PROG_TIME_NS = 40;
	localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Types.
	typedef logic [SECRET_BYTES-1:0][7:0] secret_t;
	typedef logic [BUF_BYTES-1:0][7:0] lock_block_t;
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} rx_byte_s;
	typedef enum logic [4:0] {
		RX_IDLE = 5'b00001,
		RX_START = 5'b00010,
		RX_DATA = 5'b00100,
		RX_CRC = 5'b01000,
		RX_END = 5'b10000
	} rx_state_e;
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_RECV = 5'b00010,
		ST_EVAL = 5'b00100,
		ST_PROG = 5'b01000,
		ST_ERASE = 5'b10000
	} lock_state_e;
endpackage : card_lock_pkg
`default_nettype wire

/* rtl/card_password_lock.sv */
// Password lock, unlock and forced-erase logic of a flash card, with an APB register file.
//
// Function
// - Mode byte: bit3 forced erase, bit2 lock, bit1 clear password, bit0 set password.
// - Password kept in a 128-bit store, its length in an 8-bit store.
// - While locked only basic-class and lock-class commands are permitted.
// - Forced erase is the erase bit alone, carried in a single mode byte.
// - Lock bit one locks, zero unlocks; allowed with set, ignored with clear.
// - Password lengths from one to sixteen bytes are accepted.
// - Replacement length covers both passwords; old password precedes the new one.
// - Replacement with length of the old password only fails, store unchanged.
// - Set compares old password in size and content; match stores new one.
// - Stored length zero means no password; nonzero comes up locked at reset.
// - Lock bit with a successful set also locks the card now.
// - Clear with matching password empties the store, ignoring lock bit; else fails.
// - Lock with matching password locks and sets the locked status; else fails.
// - Locking an already locked card or one without password fails.
// - Unlock with matching password unlocks for this session only; else fails.
// - Unlocking an unlocked card fails.
// - Forced erase with any other mode bit set is rejected with failure.
// - Accepted forced erase wipes content, password, length, protection; unlocks.
// - Forced erase on an unlocked card fails.
// - Forced erase on permanently protected media fails and stays locked.
`default_nettype none
module card_password_lock import card_lock_pkg::*; #(
	parameter int PROG_CYC = PROG_CYCLES
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic nv_rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic link_clk_i,
	input wire logic dat0_i,
	output logic dat0_o,
	output logic dat0_oe_o,
	input wire logic [3:0] cmd_class_i,
	output logic cmd_permit_o,
	input wire logic perm_wp_i,
	output logic erase_all_o,
	input wire logic erase_done_i,
	output logic clear_temp_wp_o,
	output logic clear_wp_groups_o,
	output logic card_locked_o
);
	if (PROG_CYC < 1 || PROG_CYC > 255) begin : g_bad_prog
		$error("card_password_lock: PROG_CYC must lie in 1 to 255.");
	end

	// Compares the first n stored bytes with the password bytes of the block.
	function automatic logic secret_match(input secret_t s, input lock_block_t b, input logic [7:0] n);
		logic m;
		m = 1'b1;
		for (int i = 0; i < SECRET_BYTES; i++) begin
			if (8'(i) < n && s[i] != b[i+2]) begin
				m = 1'b0;
			end
		end
		return m;
	endfunction : secret_match

	// Nonvolatile stores and session state.
	secret_t secret_store;
	logic [7:0] secret_length;
	logic locked;
	logic lock_failure_status;
	lock_state_e state;
	lock_block_t rx_buf;
	logic [7:0] rx_count;
	logic [7:0] blk_len;
	logic [7:0] prog_cnt;

	// Receiver link.
	rx_byte_s rx_byte;
	logic rx_done;
	logic rx_active;
	logic arm;

	// Verdict of the evaluated block.
	logic ok_set;
	logic ok_clr;
	logic ok_lock;
	logic ok_unlock;
	logic ok_erase;
	logic fail;
	logic set_locks;
	secret_t next_secret;
	logic [7:0] next_length;

	// APB decode.
	logic apb_access;
	logic apb_write;
	logic addr_hit;

	lock_block_rx #(
		.LEN_W(8)
	) u_rx (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.link_clk_i(link_clk_i),
		.dat0_i(dat0_i),
		.start_i(arm),
		.blk_len_i(blk_len),
		.byte_o(rx_byte),
		.done_o(rx_done),
		.active_o(rx_active)
	);

	// Zero-wait slave: every transfer completes in its first access cycle.
	assign apb_access = psel_i && penable_i;
	assign apb_write = apb_access && pwrite_i;
	assign pready_o = 1'b1;
	assign addr_hit = (paddr_i == OFS_CTRL) || (paddr_i == OFS_BLKLEN) ||
		(paddr_i == OFS_STATUS) || (paddr_i == OFS_SECLEN);
	assign pslverr_o = apb_access && !addr_hit;
	assign arm = apb_write && (paddr_i == OFS_CTRL) && pwdata_i[CTRL_ARM_BIT] && (state == ST_IDLE);

	// Read data comes from a flop so it is steady through the access phase.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			prdata_o <= 32'h0000_0000;
		end else if (psel_i && !penable_i && !pwrite_i) begin
			case (paddr_i)
				OFS_BLKLEN: prdata_o <= {24'h00_0000, blk_len};
				OFS_STATUS: prdata_o <= {28'h000_0000, rx_active, (state != ST_IDLE), lock_failure_status, locked};
				OFS_SECLEN: prdata_o <= {24'h00_0000, secret_length};
				default: prdata_o <= 32'h0000_0000;
			endcase
		end
	end

	// Block length register, set by the host before the lock command.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			blk_len <= BLKLEN_RESET;
		end else if (apb_write && paddr_i == OFS_BLKLEN) begin
			blk_len <= pwdata_i[7:0];
		end
	end

	// Block bytes land in flops; bytes beyond the largest legal block are dropped.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rx_buf <= '0;
			rx_count <= 8'h00;
		end else if (arm) begin
			rx_buf <= '0;
			rx_count <= 8'h00;
		end else if (rx_byte.valid) begin
			if (rx_count < 8'(BUF_BYTES)) begin
				rx_buf[rx_count[5:0]] <= rx_byte.data;
			end
			if (rx_count != 8'hFF) begin
				rx_count <= rx_count + 8'h01;
			end
		end
	end

	// Decodes the mode byte against the stores and produces one verdict.
	always_comb begin
		logic [7:0] mode;
		logic [7:0] len;
		logic has_secret;
		logic body_ok;
		logic match;
		logic [7:0] new_len;
		int idx;
		idx = 0;
		mode = rx_buf[0];
		len = rx_buf[1];
		has_secret = (secret_length != LEN_NONE);
		body_ok = ({1'b0, rx_count} >= {1'b0, len} + HDR_BYTES) && (mode[7:4] == MODE_RSVD_ZERO);
		match = secret_match(secret_store, rx_buf, secret_length);
		new_len = len - secret_length;
		ok_set = 1'b0;
		ok_clr = 1'b0;
		ok_lock = 1'b0;
		ok_unlock = 1'b0;
		ok_erase = 1'b0;
		fail = 1'b0;
		set_locks = 1'b0;
		next_secret = '0;
		next_length = new_len;
		for (int i = 0; i < SECRET_BYTES; i++) begin
			idx = i + int'(secret_length) + 2;
			if (8'(i) < new_len && idx < BUF_BYTES) begin
				next_secret[i] = rx_buf[idx];
			end
		end
		if (state == ST_EVAL) begin
			if (mode[MODE_ERASE_BIT]) begin
				// An erase request must be the erase bit alone, on a locked, erasable card.
				ok_erase = (mode == MODE_ERASE_ONLY) && locked && !perm_wp_i;
			end else if (mode[MODE_SET_BIT]) begin
				// Length must exceed the old one and leave one to sixteen new bytes.
				ok_set = body_ok && !mode[MODE_CLR_BIT] && (len > secret_length) && match &&
					(new_len >= LEN_MIN) && (new_len <= LEN_MAX);
				set_locks = mode[MODE_LOCK_BIT];
			end else if (mode[MODE_CLR_BIT]) begin
				ok_clr = body_ok && has_secret && (len == secret_length) && match;
			end else if (mode[MODE_LOCK_BIT]) begin
				ok_lock = body_ok && has_secret && !locked && (len == secret_length) && match;
			end else begin
				ok_unlock = body_ok && has_secret && locked && (len == secret_length) && match;
			end
			fail = !(ok_set || ok_clr || ok_lock || ok_unlock || ok_erase);
		end
	end

	// Sequencer: receive, evaluate, then hold busy while the stores change.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state <= ST_IDLE;
			prog_cnt <= 8'h00;
		end else begin
			case (state)
				ST_IDLE: begin
					if (arm) begin
						state <= ST_RECV;
					end
				end
				ST_RECV: begin
					if (rx_done) begin
						state <= ST_EVAL;
					end
				end
				ST_EVAL: begin
					prog_cnt <= 8'(PROG_CYC);
					if (ok_erase) begin
						state <= ST_ERASE;
					end else if (fail) begin
						state <= ST_IDLE;
					end else begin
						state <= ST_PROG;
					end
				end
				ST_PROG: begin
					prog_cnt <= prog_cnt - 8'h01;
					if (prog_cnt == 8'h01) begin
						state <= ST_IDLE;
					end
				end
				ST_ERASE: begin
					if (erase_done_i) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// The stores survive the system reset; only the blank-media init, a matching clear or a finished forced erase clears them.
	always_ff @(posedge clk_i) begin
		if (nv_rst_i) begin
			secret_store <= '0;
			secret_length <= LEN_NONE;
		end else if (ok_set) begin
			secret_store <= next_secret;
			secret_length <= next_length;
		end else if (ok_clr || (state == ST_ERASE && erase_done_i)) begin
			secret_store <= '0;
			secret_length <= LEN_NONE;
		end
	end

	// Lock state is rebuilt from the stored length at every system reset.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			locked <= (secret_length != LEN_NONE);
		end else if (ok_lock || (ok_set && set_locks)) begin
			locked <= 1'b1;
		end else if (ok_unlock || (state == ST_ERASE && erase_done_i)) begin
			locked <= 1'b0;
		end
	end

	// Sticky failure bit; a new failure wins over a clear in the same cycle.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			lock_failure_status <= 1'b0;
		end else if (fail) begin
			lock_failure_status <= 1'b1;
		end else if (apb_write && paddr_i == OFS_STATUS && pwdata_i[STAT_FAIL_BIT]) begin
			lock_failure_status <= 1'b0;
		end
	end

	// Protection clears fire once, when the erase completes.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			clear_temp_wp_o <= 1'b0;
			clear_wp_groups_o <= 1'b0;
		end else begin
			clear_temp_wp_o <= (state == ST_ERASE) && erase_done_i;
			clear_wp_groups_o <= (state == ST_ERASE) && erase_done_i;
		end
	end

	// Busy drives line 0 low; the line is released otherwise so the receiver can use it.
	assign dat0_o = 1'b0;
	assign dat0_oe_o = (state == ST_PROG) || (state == ST_ERASE);
	assign erase_all_o = (state == ST_ERASE);
	assign card_locked_o = locked;
	// A data access while locked is refused by the command decoder through this gate.
	assign cmd_permit_o = !locked || (cmd_class_i == CLASS_BASIC) || (cmd_class_i == CLASS_LOCK);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence erase_accepted;
		(state == ST_EVAL) && ok_erase;
	endsequence
	sequence erase_finished;
		(state == ST_ERASE) && erase_done_i;
	endsequence

	fail_sticky_a: assert property (fail |=> lock_failure_status [*2])
		else $error("Failure bit did not stay set after a failed command.");
	lock_ok_a: assert property (ok_lock |=> locked && (state == ST_PROG) ##[1:255]
		(state == ST_IDLE) && locked)
		else $error("Successful lock did not leave the card locked.");
	unlock_ok_a: assert property (ok_unlock |=> !locked && !card_locked_o)
		else $error("Successful unlock did not clear the lock.");
	clear_ok_a: assert property (ok_clr |=> (secret_length == LEN_NONE) && (secret_store == '0))
		else $error("Password clear left a stored length.");
	busy_low_a: assert property ((state == ST_PROG) |-> dat0_oe_o && !dat0_o)
		else $error("Line 0 not held low while programming.");
	lock_gate_a: assert property (locked && (cmd_class_i != CLASS_BASIC) &&
		(cmd_class_i != CLASS_LOCK) |-> !cmd_permit_o)
		else $error("Data command permitted on a locked card.");
	erase_reject_a: assert property ((state == ST_EVAL) && (rx_buf[0] != MODE_ERASE_ONLY) && rx_buf[0][MODE_ERASE_BIT]
		|-> fail ##1 (state == ST_IDLE))
		else $error("Mixed erase request was not rejected.");
	unlocked_unlock_a: assert property ((state == ST_EVAL) && (rx_buf[0] == 8'h00) && !locked |-> fail)
		else $error("Unlock of an unlocked card did not fail.");
	// The wipe lasts as long as the erase engine needs, so its start and its end are checked apart.
	erase_start_a: assert property (erase_accepted |=> erase_all_o && dat0_oe_o && locked)
		else $error("Accepted forced erase did not start the wipe.");
	erase_flow_a: assert property (erase_finished |=> !locked && (secret_length == LEN_NONE) &&
		clear_wp_groups_o && clear_temp_wp_o)
		else $error("Forced erase did not wipe and unlock the card.");
	erase_wp_a: assert property ((state == ST_EVAL) && perm_wp_i |-> !ok_erase ##1 (state != ST_ERASE))
		else $error("Forced erase started on permanently protected media.");
	set_lock_a: assert property (ok_set && set_locks |=> locked && (secret_length != LEN_NONE))
		else $error("Set with lock bit did not lock the card.");
endmodule : card_password_lock
`default_nettype wire

/* rtl/lock_block_rx.sv */
// Serial receiver for the lock command data block on data line 0.
`default_nettype none
module lock_block_rx import card_lock_pkg::*; #(
	parameter int LEN_W = 8
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic link_clk_i,
	input wire logic dat0_i,
	input wire logic start_i,
	input wire logic [LEN_W-1:0] blk_len_i,
	output var rx_byte_s byte_o,
	output logic done_o,
	output logic active_o
);
	if (LEN_W < 6) begin : g_bad_width
		$error("lock_block_rx: LEN_W too small for the largest lock block.");
	end

	logic [2:0] clk_sync;
	logic [2:0] dat_sync;
	logic clk_lvl;
	logic dat_lvl;
	logic link_rise;
	rx_state_e state;
	logic [2:0] bit_cnt;
	logic [LEN_W-1:0] byte_cnt;
	logic [3:0] crc_cnt;
	logic [7:0] shift;

	// Three stages per pin; a level counts only once the last two agree.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			clk_sync <= 3'b000;
			dat_sync <= 3'b111;
			clk_lvl <= 1'b0;
			dat_lvl <= 1'b1;
		end else begin
			clk_sync <= {clk_sync[1:0], link_clk_i};
			dat_sync <= {dat_sync[1:0], dat0_i};
			if (clk_sync[1] == clk_sync[2]) begin
				clk_lvl <= clk_sync[2];
			end
			if (dat_sync[1] == dat_sync[2]) begin
				dat_lvl <= dat_sync[2];
			end
		end
	end

	// The host moves data on its falling edge, so the agreed data level is settled at a rise.
	assign link_rise = (clk_sync[1] == clk_sync[2]) && clk_sync[2] && !clk_lvl;
	assign active_o = (state != RX_IDLE);

	// Start bit, payload bytes MSB first, sixteen check bits that are not verified here, end bit.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state <= RX_IDLE;
			bit_cnt <= 3'h0;
			byte_cnt <= '0;
			crc_cnt <= 4'h0;
			shift <= 8'h00;
			byte_o <= '0;
			done_o <= 1'b0;
		end else begin
			byte_o.valid <= 1'b0;
			done_o <= 1'b0;
			case (state)
				RX_IDLE: begin
					if (start_i) begin
						state <= RX_START;
					end
				end
				RX_START: begin
					if (link_rise && !dat_lvl) begin
						state <= RX_DATA;
						bit_cnt <= 3'h0;
						byte_cnt <= '0;
					end
				end
				RX_DATA: begin
					if (link_rise) begin
						shift <= {shift[6:0], dat_lvl};
						bit_cnt <= bit_cnt + 3'h1;
						if (bit_cnt == 3'h7) begin
							byte_o.valid <= 1'b1;
							byte_o.data <= {shift[6:0], dat_lvl};
							byte_cnt <= byte_cnt + 1'b1;
							if (byte_cnt + 1'b1 >= blk_len_i) begin
								state <= RX_CRC;
								crc_cnt <= 4'h0;
							end
						end
					end
				end
				RX_CRC: begin
					if (link_rise) begin
						crc_cnt <= crc_cnt + 4'h1;
						if (crc_cnt == CRC_LAST) begin
							state <= RX_END;
						end
					end
				end
				RX_END: begin
					if (link_rise) begin
						state <= RX_IDLE;
						done_o <= 1'b1;
					end
				end
				default: begin
					state <= RX_IDLE;
				end
			endcase
		end
	end
endmodule : lock_block_rx
`default_nettype wire

/* tb/card_host_model.sv */
// Host side of the card bus: sends lock command blocks bit by bit on data line 0.
`default_nettype none
module card_host_model (
	output logic link_clk_o,
	output logic dat_o,
	output logic dat_oe_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// The bus clock stands still low between frames, as a real host may stop it.
	initial begin
		link_clk_o = 1'b0;
		dat_o = 1'b1;
		dat_oe_o = 1'b0;
	end

	// One bit: data changes after the falling edge and is taken at the rising edge.
	task automatic bit_out(input logic v);
		dat_o = v;
		#62.5 link_clk_o = 1'b1;
		#62.5 link_clk_o = 1'b0;
	endtask : bit_out

	// Whole block: start bit, bytes MSB first, sixteen check bits, end bit, then eight idle clocks.
	task automatic send(input logic [7:0] b[$]);
		dat_oe_o = 1'b1;
		bit_out(1'b0);
		foreach (b[i]) for (int k = 7; k >= 0; k--) bit_out(b[i][k]);
		for (int k = 0; k < 16; k++) bit_out(k[0]);
		bit_out(1'b1);
		// Released line floats up to the pull-up level, so the card sees ones.
		dat_oe_o = 1'b0;
		repeat (8) bit_out(1'b0);
	endtask : send
endmodule : card_host_model
`default_nettype wire

/* tb/card_password_lock_test.sv */
// Self-checking bench of the card password lock block with a reference model.
`default_nettype none
module card_password_lock_test import card_lock_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk_i, sys_rst_i, nv_rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o;
	logic link_clk, h_dat, h_oe, dat0_o, dat0_oe_o, dat0_line;
	logic [3:0] cmd_class_i;
	logic cmd_permit_o, perm_wp_i, erase_all_o, erase_done_i, clear_temp_wp_o, clear_wp_groups_o, card_locked_o;
	int n_mismatch = 0, checks_done = 0, cycles = 0, ecnt = 0, pulses, busy_seen;
	int seed = 32'h591e;
	int m_locked, m_fail;
	int secret[$];
	logic [7:0] fr[$];

	// Line level: card busy wins, else host, else the pull-up.
	assign dat0_line = dat0_oe_o ? dat0_o : (h_oe ? h_dat : 1'b1);

	card_host_model HOST (.link_clk_o(link_clk), .dat_o(h_dat), .dat_oe_o(h_oe));

	card_password_lock DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .nv_rst_i(nv_rst_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .link_clk_i(link_clk),
		.dat0_i(dat0_line), .dat0_o(dat0_o), .dat0_oe_o(dat0_oe_o), .cmd_class_i(cmd_class_i),
		.cmd_permit_o(cmd_permit_o), .perm_wp_i(perm_wp_i), .erase_all_o(erase_all_o),
		.erase_done_i(erase_done_i), .clear_temp_wp_o(clear_temp_wp_o),
		.clear_wp_groups_o(clear_wp_groups_o), .card_locked_o(card_locked_o));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// Erase engine stub, busy and pulse monitors, and the hang guard.
	always @(posedge clk_i) begin
		erase_done_i <= (ecnt == 20);
		ecnt <= erase_all_o ? ecnt + 1 : 0;
		if (dat0_oe_o === 1'b1) busy_seen <= 1;
		if (clear_temp_wp_o === 1'b1 && clear_wp_groups_o === 1'b1) pulses <= pulses + 1;
		cycles <= cycles + 1;
		if (cycles == 95000) begin
			n_mismatch++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : stop_test

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// One APB transfer; the request is held until pready is seen high.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
			output logic e);
		@(posedge clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do @(posedge clk_i); while (pready_o !== 1'b1);
		r = prdata_o;
		e = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb

	task automatic do_reset(input logic nv);
		sys_rst_i <= 1'b1;
		nv_rst_i <= nv;
		repeat (5) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		nv_rst_i <= 1'b0;
		m_locked = secret.size() != 0;
		m_fail = 0;
	endtask : do_reset

	// Old password bytes sent at byte 2 onward equal the stored one, in size and content.
	function automatic int same(input int n);
		if (n == 0 || secret.size() != n || fr.size() < 2 + n) return 0;
		for (int i = 0; i < n; i++) if (fr[2+i] != secret[i]) return 0;
		return 1;
	endfunction : same

	// Sends one lock command block and compares the design with the model.
	task automatic do_cmd(input logic [7:0] mode, input logic [7:0] len, input int nold, input int bad,
			input int nnew, input string name);
		logic [31:0] r;
		logic e;
		int p, ok, nl, old;
		fr = {mode};
		if (!mode[3]) fr.push_back(len);
		for (int i = 0; i < nold; i++) fr.push_back(8'(secret[i] ^ ((i == 0) ? bad : 0)));
		for (int i = 0; i < nnew; i++) fr.push_back(8'($random(seed)));
		apb(1'b1, OFS_BLKLEN, 32'(fr.size()), r, e);
		apb(1'b1, OFS_CTRL, 32'h0000_0001, r, e);
		busy_seen = 0;
		pulses = 0;
		HOST.send(fr);
		p = 0;
		do begin
			apb(1'b0, OFS_STATUS, 32'h0000_0000, r, e);
			p++;
		end while (r[3:2] !== 2'b00 && p < 400);
		// A card that never leaves busy is a failure in its own right.
		if (r[3:2] !== 2'b00) n_mismatch++;
		old = secret.size();
		nl = len - old;
		if (mode[7:4] != 0 || (mode[0] && mode[1]) || (mode[3] && mode != 8'h08)) ok = 0;
		else if (mode[3]) ok = m_locked && !perm_wp_i;
		else if (fr.size() < 2 + len) ok = 0;
		else if (mode[0]) ok = (old == 0 || same(old)) && nl >= 1 && nl <= 16;
		else if (mode[1]) ok = same(len);
		else if (mode[2]) ok = !m_locked && same(len);
		else ok = m_locked && same(len);
		if (!ok) m_fail = 1;
		else if (mode[3]) begin
			secret = {};
			m_locked = 0;
		end else if (mode[0]) begin
			secret = {};
			for (int i = 0; i < nl; i++) secret.push_back(fr[2+old+i]);
			if (mode[2]) m_locked = 1;
		end else if (mode[1]) secret = {};
		else m_locked = mode[2];
		check({name, " status"}, 32'(m_fail * 2 + m_locked), r);
		check({name, " locked pin"}, 32'(m_locked), 32'(card_locked_o));
		check({name, " busy"}, 32'(ok), 32'(busy_seen));
		check({name, " wp clears"}, 32'(ok && mode[3]), 32'(pulses));
		apb(1'b0, OFS_SECLEN, 32'h0000_0000, r, e);
		check({name, " length"}, 32'(secret.size()), r);
		cmd_class_i <= 4'($random(seed));
		repeat (2) @(posedge clk_i);
		check({name, " permit"}, 32'(!m_locked || cmd_class_i == 0 || cmd_class_i == 7),
			32'(cmd_permit_o));
		apb(1'b1, OFS_STATUS, 32'h0000_0002, r, e);
		m_fail = 0;
		$display("test %s done", name);
	endtask : do_cmd

	// Main sequence: blank media, then every mode in good and bad variants.
	initial begin
		logic [31:0] rd;
		logic er;
		{sys_rst_i, nv_rst_i, psel_i, penable_i, pwrite_i, perm_wp_i, erase_done_i} = '0;
		paddr_i = 12'h000;
		pwdata_i = 32'h0000_0000;
		cmd_class_i = 4'h0;
		do_reset(1'b1);
		apb(1'b0, 12'h010, 32'h0000_0000, rd, er);
		check("unmapped error", 32'h0000_0001, 32'(er));
		check("unmapped data", 32'h0000_0000, rd);
		apb(1'b0, OFS_BLKLEN, 32'h0000_0000, rd, er);
		check("block length reset", 32'(BLKLEN_RESET), rd);
		do_cmd(8'h04, 8'd0, 0, 0, 0, "lock without secret");
		do_cmd(8'h00, 8'd0, 0, 0, 0, "unlock unlocked");
		do_cmd(8'h08, 8'd0, 0, 0, 0, "erase unlocked");
		do_cmd(8'h01, 8'd17, 0, 0, 17, "set too long");
		do_cmd(8'h01, 8'd16, 0, 0, 16, "set sixteen");
		do_cmd(8'h01, 8'd16, 16, 0, 0, "replace old only");
		do_cmd(8'h05, 8'd19, 16, 1, 3, "replace bad old");
		do_cmd(8'h05, 8'd19, 16, 0, 3, "replace and lock");
		do_cmd(8'h04, 8'd3, 3, 0, 0, "lock locked");
		do_cmd(8'h00, 8'd3, 3, 1, 0, "unlock bad");
		do_cmd(8'h00, 8'd3, 3, 0, 0, "unlock");
		do_cmd(8'h04, 8'd3, 3, 1, 0, "lock bad");
		do_cmd(8'h04, 8'd3, 3, 0, 0, "lock");
		do_cmd(8'h00, 8'd3, 3, 0, 0, "unlock again");
		do_cmd(8'h03, 8'd3, 3, 0, 0, "set with clear");
		do_cmd(8'h12, 8'd3, 3, 0, 0, "reserved bit");
		do_cmd(8'h02, 8'd3, 3, 1, 0, "clear bad");
		do_cmd(8'h06, 8'd3, 3, 0, 0, "clear with lock bit");
		do_cmd(8'h01, 8'd1, 0, 0, 1, "set one byte");
		do_reset(1'b0);
		@(posedge clk_i);
		check("locked after reset", 32'h0000_0001, 32'(card_locked_o));
		do_cmd(8'h0C, 8'd0, 0, 0, 0, "erase with lock bit");
		perm_wp_i <= 1'b1;
		do_cmd(8'h08, 8'd0, 0, 0, 0, "erase protected");
		perm_wp_i <= 1'b0;
		do_cmd(8'h08, 8'd0, 0, 0, 0, "forced erase");
		stop_test();
	end
endmodule : card_password_lock_test
`default_nettype wire
